//--- bench/rtcl_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// far side of the count and trigger pins
module rtcl_pin_model
(
	input  wire logic clk,
	input  wire logic countPinOut,
	input  wire logic countPinOe,
	output logic      countPinIn,
	output logic      trigPinIn
);
	logic drvLvl = 1'b1;
	logic trigLvl = 1'b1;

	// pin has a pull-up, so it reads high when nobody drives it
	assign countPinIn = countPinOe ? countPinOut : drvLvl;
	assign trigPinIn  = trigLvl;

	// low held 3 clocks and high 4, above the 2 clock minimum
	task automatic countFalls(input int n);
		repeat (n)
		begin
			@(posedge clk) drvLvl <= 1'b0;
			repeat (3) @(posedge clk);
			drvLvl <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic setTrig(input logic lvl);
		@(posedge clk) trigLvl <= lvl;
		repeat (4) @(posedge clk);
	endtask

	task automatic trigFall();
		setTrig(1'b0);
		setTrig(1'b1);
	endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import rtcl_pkg::*;
;
	logic        clk;
	logic        sysRst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        otherOvf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        countPinIn;
	logic        countPinOut;
	logic        countPinOe;
	logic        trigPinIn;
	logic        rxBaudTick;
	logic        txBaudTick;
	logic        timerIntReq;
	logic [31:0] rdData;
	logic        rdErr;
	int          n_errors = 0;
	int          n_compared = 0;
	int          rxTicks = 0;
	int          txTicks = 0;
	int          n;

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	rtcl_timer dut
	(
		.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .countPinIn(countPinIn),
		.countPinOut(countPinOut), .countPinOe(countPinOe), .trigPinIn(trigPinIn),
		.otherTimerOvf(otherOvf), .rxBaudTick(rxBaudTick),
		.txBaudTick(txBaudTick), .timerIntReq(timerIntReq)
	);

	rtcl_pin_model pins
	(
		.clk(clk), .countPinOut(countPinOut), .countPinOe(countPinOe),
		.countPinIn(countPinIn), .trigPinIn(trigPinIn)
	);

	always @(posedge clk)
	begin
		if (rxBaudTick === 1'b1)
			rxTicks <= rxTicks + 1;
		if (txBaudTick === 1'b1)
			txTicks <= txTicks + 1;
	end

	// =========================================================
	// checking and bus tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && w < 20)
		begin
			@(posedge clk);
			w++;
		end
		if (pready !== 1'b1)
		begin
			n_errors++;
			$display("ERROR at %0t: no bus answer", $time);
		end
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdData, exp);
	endtask

	// time between clock-out level changes, sampled off the active edge
	task automatic span(output int k);
		logic v;
		k = 0;
		v = countPinOut;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (countPinOut === v && k < 64);
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("ERROR at %0t: watchdog expired", $time);
		summarize();
	end

	// =========================================================
	// tests
	initial
	begin
		sysRst <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		otherOvf <= 1'b0;
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		rd(RTCL_CTRL_OFS, 32'h0);
		rd(RTCL_MODE_OFS, 32'h0);
		wr(RTCL_MODE_OFS, 32'h3);
		rd(RTCL_MODE_OFS, 32'h3);
		wr(RTCL_MODE_OFS, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, rdErr}, 32'h1);
		wr(RTCL_BITOP_OFS, 32'h102);
		rd(RTCL_CTRL_OFS, 32'h04);
		wr(RTCL_BITOP_OFS, 32'h002);
		rd(RTCL_CTRL_OFS, 32'h00);
		$display("test registers done");
		wr(RTCL_COUNT_OFS, 32'h00fb);
		wr(RTCL_CTRL_OFS, 32'h06);
		pins.countFalls(5);
		rd(RTCL_COUNT_OFS, 32'h0100);
		wr(RTCL_CTRL_OFS, 32'h02);
		pins.countFalls(2);
		rd(RTCL_COUNT_OFS, 32'h0100);
		$display("test counting done");
		wr(RTCL_RELOAD_OFS, 32'h1234);
		wr(RTCL_COUNT_OFS, 32'hfffe);
		wr(RTCL_CTRL_OFS, 32'h06);
		pins.countFalls(2);
		rd(RTCL_COUNT_OFS, 32'h1234);
		rd(RTCL_CTRL_OFS, 32'h86);
		chk(timerIntReq, 1'b1);
		$display("test overflow done");
		wr(RTCL_CTRL_OFS, 32'h26);
		wr(RTCL_COUNT_OFS, 32'hfffe);
		pins.countFalls(2);
		rd(RTCL_COUNT_OFS, 32'h1234);
		rd(RTCL_CTRL_OFS, 32'h26);
		@(posedge clk) otherOvf <= 1'b1;
		@(posedge clk) otherOvf <= 1'b0;
		repeat (3) @(posedge clk);
		chk(rxTicks, 1);
		chk(txTicks, 1);
		wr(RTCL_CTRL_OFS, 32'h2e);
		pins.trigFall();
		rd(RTCL_CTRL_OFS, 32'h2e);
		$display("test baud done");
		wr(RTCL_CTRL_OFS, 32'h0a);
		wr(RTCL_COUNT_OFS, 32'h0042);
		pins.trigFall();
		rd(RTCL_COUNT_OFS, 32'h1234);
		rd(RTCL_CTRL_OFS, 32'h4a);
		chk(timerIntReq, 1'b1);
		wr(RTCL_CTRL_OFS, 32'h0b);
		wr(RTCL_COUNT_OFS, 32'h0077);
		pins.trigFall();
		rd(RTCL_RELOAD_OFS, 32'h0077);
		rd(RTCL_COUNT_OFS, 32'h0077);
		rd(RTCL_CTRL_OFS, 32'h4b);
		wr(RTCL_CTRL_OFS, 32'h01);
		wr(RTCL_RELOAD_OFS, 32'h0);
		pins.trigFall();
		rd(RTCL_RELOAD_OFS, 32'h0);
		$display("test trigger done");
		wr(RTCL_MODE_OFS, 32'h1);
		wr(RTCL_RELOAD_OFS, 32'h0010);
		wr(RTCL_COUNT_OFS, 32'h0011);
		pins.setTrig(1'b0);
		wr(RTCL_CTRL_OFS, 32'h06);
		pins.countFalls(2);
		rd(RTCL_COUNT_OFS, 32'hffff);
		rd(RTCL_CTRL_OFS, 32'hc6);
		wr(RTCL_CTRL_OFS, 32'h46);
		@(negedge clk);
		chk(timerIntReq, 1'b0);
		pins.setTrig(1'b1);
		pins.countFalls(1);
		rd(RTCL_COUNT_OFS, 32'h0010);
		rd(RTCL_CTRL_OFS, 32'h86);
		$display("test up/down done");
		wr(RTCL_MODE_OFS, 32'h2);
		wr(RTCL_CTRL_OFS, 32'h00);
		wr(RTCL_RELOAD_OFS, 32'hfffe);
		wr(RTCL_COUNT_OFS, 32'hfffe);
		wr(RTCL_CTRL_OFS, 32'h04);
		span(n);
		span(n);
		chk(n, 4);
		span(n);
		chk(n, 4);
		chk(countPinIn, countPinOut);
		chk(countPinOe, 1'b1);
		rd(RTCL_CTRL_OFS, 32'h04);
		$display("test clock-out done");
		wr(RTCL_MODE_OFS, 32'h0);
		wr(RTCL_CTRL_OFS, 32'h00);
		wr(RTCL_COUNT_OFS, 32'h0);
		wr(RTCL_CTRL_OFS, 32'h04);
		repeat (1200) @(posedge clk);
		wr(RTCL_CTRL_OFS, 32'h00);
		apb(1'b0, RTCL_COUNT_OFS, 32'h0);
		chk(rdData >= 32'h64 && rdData <= 32'h65, 1'b1);
		$display("test divided clock done");
		wr(RTCL_MODE_OFS, 32'h3);
		wr(RTCL_CTRL_OFS, 32'h3b);
		@(posedge clk) sysRst <= 1'b1;
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		rd(RTCL_CTRL_OFS, 32'h00);
		rd(RTCL_MODE_OFS, 32'h0);
		chk(countPinOe, 1'b0);
		$display("test mid-run reset done");
		summarize();
	end
endmodule
`default_nettype wire

//--- logic/rtcl_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rtcl_pin_sync
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pinIn,
	output logic      pinLevel,
	output logic      pinFall
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end
		else
		begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign pinLevel = sync_q;
	assign pinFall  = prev_q & ~sync_q;

endmodule
`default_nettype wire

//--- logic/rtcl_pkg.sv
`default_nettype none
package rtcl_pkg;

	// =========================================================
	// register byte addresses
	localparam logic [11:0] RTCL_CTRL_OFS   = 12'h0c8;
	localparam logic [11:0] RTCL_MODE_OFS   = 12'h0cc;
	localparam logic [11:0] RTCL_RELOAD_OFS = 12'h0d0;
	localparam logic [11:0] RTCL_COUNT_OFS  = 12'h0d4;
	localparam logic [11:0] RTCL_BITOP_OFS  = 12'h0d8;

	// =========================================================
	// timer_two_control field positions
	localparam int RTCL_BIT_OVF  = 7;
	localparam int RTCL_BIT_EXT  = 6;
	localparam int RTCL_BIT_RCLK = 5;
	localparam int RTCL_BIT_SERIAL_TX_CLOCK_SELECT = 4;
	localparam int RTCL_BIT_EXEN = 3;
	localparam int RTCL_BIT_RUN  = 2;
	localparam int RTCL_BIT_CSEL = 1;
	localparam int RTCL_BIT_CPRL = 0;

	// timer_two_mode_reg field positions
	localparam int RTCL_BIT_OE   = 1;
	localparam int RTCL_BIT_DOWN_COUNT_ENABLE = 0;

	// bit-operation register: index in [2:0], value in [8]
	localparam int RTCL_BITOP_VAL = 8;

	// =========================================================
	// reset values and counts
	localparam logic [7:0]  RTCL_CTRL_RST  = 8'h00;
	localparam logic [1:0]  RTCL_MODE_RST  = 2'h0;
	localparam logic [15:0] RTCL_COUNT_TOP = 16'hffff;
	localparam logic [3:0]  RTCL_DIV_TIMER = 4'hb;

	typedef enum logic [1:0]
	{
		RTCL_MODE_CAPTURE,
		RTCL_MODE_RELOAD,
		RTCL_MODE_UPDOWN,
		RTCL_MODE_BAUD
	} rtcl_mode_type;

endpackage
`default_nettype wire

//--- logic/rtcl_timer.sv
// Summary of operation
// - count is a low byte and a high byte; high advances on low carry
// - counter-select set counts count-pin falls, else clock divided by 12 (by 2 in clock-out mode)
// - count advances only while run-control is set
// - either serial clock select forces auto-reload, ignoring capture select
// - reload on overflow (not in capture mode without clock-out, which wraps to 0000) and enabled trigger fall; capture select makes trigger capture
// - trigger edges ignored unless enabled and timer neither clocking serial port nor in up/down mode
// - enabled trigger capture or reload sets external flag; it requests interrupt while down-count enable is clear
// - overflow flag set on overflow only when both serial selects clear
// - each serial direction takes this overflow when selected, else other timer
// - down-count enable in auto-reload makes trigger level choose direction
// - up count overflows at ffff, sets flag, loads reload pair
// - down count underflows at reload value, sets flag, loads ffff
// - up/down mode without clock-out toggles external flag per wrap without interrupt
// - clock-out mode counts at clock over 2, reloads, raises no interrupt on wrap (enabled trigger falls still set external flag)
// - clock-out pin toggles per overflow, giving 50% duty square wave
// - baud supply and clock-out may run together sharing the reload pair
// - control register resets to zero; each bit writable on its own
// - mode register holds output enable bit 1, down enable bit 0
`timescale 1ns/1ps
`default_nettype none
module rtcl_timer
	import rtcl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        countPinIn,
	output logic             countPinOut,
	output logic             countPinOe,
	input  wire logic        trigPinIn,
	input  wire logic        otherTimerOvf,
	output logic             rxBaudTick,
	output logic             txBaudTick,
	output logic             timerIntReq
);

	// =========================================================
	// address decode
	function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] ofs);
		addrHit = (addr[11:2] == ofs[11:2]);
	endfunction

	logic [7:0]    ctrl_q;
	logic [7:0]    ctrl_d;
	logic [1:0]    mode_q;
	logic [7:0]    reloadLow_q;
	logic [7:0]    reloadHigh_q;
	logic [7:0]    countLow_q;
	logic [7:0]    countHigh_q;
	logic [7:0]    countLow_d;
	logic [7:0]    countHigh_d;
	logic [3:0]    div_q;
	logic          half_q;
	logic          pinOut_q;
	logic          rxTick_q;
	logic          txTick_q;
	logic [31:0]   rdata_q;
	rtcl_mode_type timerMode;

	wire hitCtrl   = addrHit(paddr, RTCL_CTRL_OFS);
	wire hitMode   = addrHit(paddr, RTCL_MODE_OFS);
	wire hitReload = addrHit(paddr, RTCL_RELOAD_OFS);
	wire hitCount  = addrHit(paddr, RTCL_COUNT_OFS);
	wire hitBitop  = addrHit(paddr, RTCL_BITOP_OFS);
	wire mapped    = hitCtrl | hitMode | hitReload | hitCount | hitBitop;
	wire setupRd   = psel & ~penable & ~pwrite;
	wire wrEn      = psel & penable & pwrite & mapped;
	wire ctrlWr    = wrEn & hitCtrl;
	wire modeWr    = wrEn & hitMode;
	wire reloadWr  = wrEn & hitReload;
	wire countWr   = wrEn & hitCount;
	wire bitWr     = wrEn & hitBitop;

	// zero wait states: every access phase completes at its first edge
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = rdata_q;

	// =========================================================
	// control fields
	wire ovfFlag  = ctrl_q[RTCL_BIT_OVF];
	wire extFlag  = ctrl_q[RTCL_BIT_EXT];
	wire rclkSel  = ctrl_q[RTCL_BIT_RCLK];
	wire tclkSel  = ctrl_q[RTCL_BIT_SERIAL_TX_CLOCK_SELECT];
	wire extEn    = ctrl_q[RTCL_BIT_EXEN];
	wire runCtl   = ctrl_q[RTCL_BIT_RUN];
	wire countSel = ctrl_q[RTCL_BIT_CSEL];
	wire capSel   = ctrl_q[RTCL_BIT_CPRL];
	wire outEn    = mode_q[RTCL_BIT_OE];
	wire downEn   = mode_q[RTCL_BIT_DOWN_COUNT_ENABLE];
	wire baudSel  = rclkSel | tclkSel;
	// clock-out needs counter-select clear; otherwise the pin is still driven, held low
	wire clkOut   = outEn & ~countSel;

	assign timerMode = baudSel ? RTCL_MODE_BAUD :
		capSel ? RTCL_MODE_CAPTURE :
		downEn ? RTCL_MODE_UPDOWN : RTCL_MODE_RELOAD;

	wire isCapture = (timerMode == RTCL_MODE_CAPTURE);
	wire isReload  = (timerMode == RTCL_MODE_RELOAD);
	wire isUpdown  = (timerMode == RTCL_MODE_UPDOWN);

	// =========================================================
	// pin synchronisers
	logic countLevel;
	logic countFall;
	logic trigLevel;
	logic trigFall;

	rtcl_pin_sync countSync
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.pinIn    (countPinIn),
		.pinLevel (countLevel),
		.pinFall  (countFall)
	);

	rtcl_pin_sync trigSync
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.pinIn    (trigPinIn),
		.pinLevel (trigLevel),
		.pinFall  (trigFall)
	);

	// =========================================================
	// prescalers
	wire tick12 = (div_q == RTCL_DIV_TIMER);
	wire tick2  = half_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			div_q  <= 4'h0;
			half_q <= 1'b0;
		end
		else
		begin
			div_q  <= tick12 ? 4'h0 : div_q + 4'h1;
			half_q <= ~half_q;
		end
	end

	// =========================================================
	// count events
	wire [15:0] count16  = {countHigh_q, countLow_q};
	wire [15:0] reload16 = {reloadHigh_q, reloadLow_q};
	// own clock-out pin level is ignored as count source via clkOut
	wire srcTick   = clkOut ? tick2 : (countSel ? countFall : tick12);
	wire countTick = runCtl & srcTick;
	wire upDir     = ~isUpdown | trigLevel;
	wire ovfUp     = countTick & upDir & (count16 == RTCL_COUNT_TOP);
	wire undDown   = countTick & ~upDir & (count16 == reload16);
	wire wrapEv    = ovfUp | undDown;
	wire trigEvent = trigFall & extEn & (isCapture | isReload);
	wire doCapture = trigEvent & isCapture;
	wire doReload  = (ovfUp & (~isCapture | clkOut))
		| (trigEvent & isReload);
	wire setOvf    = wrapEv & ~baudSel & ~clkOut;
	wire exfSet    = trigEvent;
	wire exfToggle = wrapEv & isUpdown & ~clkOut;

	// =========================================================
	// count next value; cascaded bytes
	always_comb
	begin
		countLow_d  = countLow_q;
		countHigh_d = countHigh_q;
		if (countWr)
		begin
			countLow_d  = pwdata[7:0];
			countHigh_d = pwdata[15:8];
		end
		else if (undDown)
		begin
			countLow_d  = RTCL_COUNT_TOP[7:0];
			countHigh_d = RTCL_COUNT_TOP[15:8];
		end
		else if (doReload)
		begin
			countLow_d  = reloadLow_q;
			countHigh_d = reloadHigh_q;
		end
		else if (countTick & upDir)
		begin
			countLow_d  = countLow_q + 8'h01;
			if (countLow_q == 8'hff)
				countHigh_d = countHigh_q + 8'h01;
		end
		else if (countTick)
		begin
			countLow_d  = countLow_q - 8'h01;
			if (countLow_q == 8'h00)
				countHigh_d = countHigh_q - 8'h01;
		end
	end

	// =========================================================
	// control register: full write or single-bit write
	wire [7:0] bitMask = 8'h01 << pwdata[2:0];
	wire [7:0] ctrlBit = pwdata[RTCL_BITOP_VAL] ? (ctrl_q | bitMask) : (ctrl_q & ~bitMask);
	wire [7:0] ctrlSw  = ctrlWr ? pwdata[7:0] : (bitWr ? ctrlBit : ctrl_q);

	// hardware set wins over a software clear in the same cycle
	always_comb
	begin
		ctrl_d = ctrlSw;
		ctrl_d[RTCL_BIT_OVF] = ctrlSw[RTCL_BIT_OVF] | setOvf;
		ctrl_d[RTCL_BIT_EXT] = (ctrlSw[RTCL_BIT_EXT] | exfSet) ^ exfToggle;
	end

	// =========================================================
	// read data mux
	wire [31:0] rdWord = hitCtrl   ? {24'h000000, ctrl_q} :
		hitMode   ? {30'h0, mode_q} :
		hitReload ? {16'h0000, reload16} :
		hitCount  ? {16'h0000, count16} : 32'h00000000;

	// =========================================================
	// registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_q <= RTCL_CTRL_RST;
			mode_q <= RTCL_MODE_RST;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			if (modeWr)
				mode_q <= pwdata[1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			countLow_q  <= 8'h00;
			countHigh_q <= 8'h00;
		end
		else
		begin
			countLow_q  <= countLow_d;
			countHigh_q <= countHigh_d;
		end
	end

	// one reload pair feeds baud, clock-out and reload alike
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			reloadLow_q  <= 8'h00;
			reloadHigh_q <= 8'h00;
		end
		else if (reloadWr)
		begin
			reloadLow_q  <= pwdata[7:0];
			reloadHigh_q <= pwdata[15:8];
		end
		else if (doCapture)
		begin
			reloadLow_q  <= countLow_q;
			reloadHigh_q <= countHigh_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pinOut_q <= 1'b0;
			rxTick_q <= 1'b0;
			txTick_q <= 1'b0;
			rdata_q  <= 32'h00000000;
		end
		else
		begin
			if (~clkOut)
				pinOut_q <= 1'b0;
			else if (ovfUp)
				pinOut_q <= ~pinOut_q;
			rxTick_q <= rclkSel ? wrapEv : otherTimerOvf;
			txTick_q <= tclkSel ? wrapEv : otherTimerOvf;
			if (setupRd)
				rdata_q <= rdWord;
		end
	end

	assign countPinOut = pinOut_q;
	assign countPinOe  = outEn;
	assign rxBaudTick  = rxTick_q;
	assign txBaudTick  = txTick_q;
	// external flag is no interrupt source in up/down mode
	assign timerIntReq = ovfFlag | (extFlag & ~downEn);

	// =========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	ovf_flag_set_a: assert property (setOvf |=> ovfFlag)
		else $error("overflow flag not set after overflow");

	baud_no_flag_a: assert property ($rose(ovfFlag) |-> $past(~baudSel) || $past(ctrlWr || bitWr))
		else $error("overflow flag set while serial clock selected");

	reload_load_a: assert property (doReload && !countWr && !undDown |=> count16 == $past(reload16))
		else $error("count not loaded from reload pair");

	underflow_top_a: assert property (undDown && !countWr |=> count16 == 16'hffff)
		else $error("underflow did not load ffff");

	stopped_hold_a: assert property (!runCtl && !countWr && !doReload |=> $stable(count16))
		else $error("count moved while stopped");

	capture_copy_a: assert property (doCapture && !reloadWr && !countWr && !countTick
		|=> reload16 == $past(count16) && count16 == $past(count16))
		else $error("capture did not copy count");

	ext_toggle_a: assert property (exfToggle && !ctrlWr && !bitWr |=> extFlag != $past(extFlag))
		else $error("external flag did not toggle on wrap");

	updown_no_irq_a: assert property (isUpdown && downEn && !ovfFlag |-> !timerIntReq)
		else $error("interrupt from external flag in up/down mode");

	clockout_toggle_a: assert property (clkOut && ovfUp |=> countPinOut != $past(countPinOut))
		else $error("clock-out pin did not toggle");

	prescale_gap_a: assert property (tick12 |=> !tick12 [*8])
		else $error("timer prescaler ticks too close");

	carry_high_a: assert property (countTick && upDir && countLow_q == 8'hff && !doReload
		&& !countWr |=> countHigh_q == $past(countHigh_q) + 8'h01)
		else $error("high byte missed low byte carry");

	cover_updown_wrap: cover property (isUpdown && undDown);
	cover_capture: cover property (doCapture);
	cover_clockout: cover property (clkOut && ovfUp && baudSel);
	cover_trig_reload: cover property (trigEvent && isReload);

endmodule
`default_nettype wire
